/* File: rtl/xio_pkg.sv */
package xio_pkg;
    localparam logic [3:0] XIO_REG_DIR = 4'h0;
    localparam logic [3:0] XIO_REG_PTSEL = 4'h1;
    localparam logic [3:0] XIO_REG_BITCMD = 4'h2;
    localparam logic [3:0] XIO_REG_MAIN = 4'h3;
    localparam logic [3:0] XIO_REG_EXTA = 4'h4;
    localparam logic [3:0] XIO_REG_EXTB = 4'h5;
    localparam logic [3:0] XIO_REG_EXTC = 4'h6;
    localparam logic [3:0] XIO_REG_EXTD = 4'h7;
    localparam logic [3:0] XIO_REG_BLKRD = 4'h8;
    localparam logic [3:0] XIO_REG_BITRD = 4'h9;
    localparam logic [3:0] XIO_REG_SAVE = 4'ha;
    localparam logic [3:0] XIO_REG_STAT = 4'hb;
    localparam logic [7:0] XIO_DIR_RESET = 8'h00;
    localparam logic [6:0] XIO_EXT_FIRST = 7'h11;
    localparam logic [6:0] XIO_EXT_LAST = 7'h50;
    localparam logic [6:0] XIO_MAIN_LAST = 7'h08;
    localparam logic [6:0] XIO_MAIN_LAST_BIG = 7'h10;
    localparam logic [3:0] XIO_BLK_FIRST = 4'h2;
    localparam logic [3:0] XIO_BLK_LAST = 4'h9;
    localparam int XIO_BITCMD_CLR = 0;
    localparam int XIO_BITCMD_SET = 1;
    localparam int XIO_BITCMD_COND = 2;
    localparam int XIO_BITCMD_CVAL = 3;
    localparam int XIO_STAT_BUSY = 0;
    localparam int XIO_STAT_VALID = 1;
    typedef enum logic [1:0] {
        XIO_NV_IDLE = 2'b00,
        XIO_NV_SAVE = 2'b01,
        XIO_NV_LOAD = 2'b10
    } xio_nv_t;
endpackage : xio_pkg

/* File: rtl/xio_ext_io.sv */
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module xio_ext_io
    import xio_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic bigVariant,
    input wire logic [5:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output logic [1:0] avsResponse,
    input wire logic [63:0] extPinIn,
    output logic [63:0] extPinOut,
    output logic [63:0] extPinOe,
    output logic [15:0] mainOut,
    input wire logic [15:0] mainIn,
    output logic nvWrite,
    output logic [87:0] nvWriteData,
    output logic nvRead,
    input wire logic nvReadValid,
    input wire logic [87:0] nvReadData,
    input wire logic nvHasData,
    input wire logic nvDone
);
    ////////////////////////////////////////////////////////////////////////
    logic [63:0] syncA_ff, syncB_ff, syncC_ff, pinStable_ff, nxt_pinStable;
    logic [15:0] mainA_ff, mainB_ff, mainC_ff, mainStable_ff, nxt_mainStable;
    logic [7:0] dir_ff, nxt_dir;
    logic [63:0] outLat_ff, nxt_outLat;
    logic [15:0] mainLat_ff, nxt_mainLat;
    logic [6:0] ptSel_ff, nxt_ptSel;
    logic [3:0] blkSel_ff, nxt_blkSel;
    logic [31:0] rdData_ff, nxt_rdData;
    logic rdDone_ff, nxt_rdDone;
    xio_nv_t nv_ff, nxt_nv;
    logic loaded_ff, nxt_loaded;
    logic [3:0] regIdx;
    logic [63:0] outMask;

    // Point number to extended bit index and validity
    function automatic logic extValid(input logic [6:0] pt);
        extValid = (pt >= XIO_EXT_FIRST) && (pt <= XIO_EXT_LAST);
    endfunction : extValid

    function automatic logic [5:0] extIdx(input logic [6:0] pt);
        logic [6:0] d;
        d = pt - XIO_EXT_FIRST;
        extIdx = d[5:0];
    endfunction : extIdx

    function automatic logic [63:0] blockMask(input logic [7:0] dir);
        logic [63:0] m;
        m = '0;
        for (int b = 0; b < 8; b++) begin
            m[b*8 +: 8] = {8{dir[b]}};
        end
        blockMask = m;
    endfunction : blockMask

    assign regIdx = avsAddress[5:2];
    assign outMask = blockMask(dir_ff);

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    always_comb begin
        nxt_pinStable = pinStable_ff;
        nxt_mainStable = mainStable_ff;
        for (int i = 0; i < 64; i++) begin
            if (syncB_ff[i] == syncC_ff[i]) begin
                nxt_pinStable[i] = syncC_ff[i];
            end
        end
        for (int i = 0; i < 16; i++) begin
            if (mainB_ff[i] == mainC_ff[i]) begin
                nxt_mainStable[i] = mainC_ff[i];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
            syncC_ff <= '0;
            pinStable_ff <= '0;
            mainA_ff <= '0;
            mainB_ff <= '0;
            mainC_ff <= '0;
            mainStable_ff <= '0;
        end else if (clkEn) begin
            syncA_ff <= extPinIn;
            syncB_ff <= syncA_ff;
            syncC_ff <= syncB_ff;
            pinStable_ff <= nxt_pinStable;
            mainA_ff <= mainIn;
            mainB_ff <= mainA_ff;
            mainC_ff <= mainB_ff;
            mainStable_ff <= nxt_mainStable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes, bit commands, nonvolatile sequencing
    logic [15:0] pwArg;
    logic [1:0] pwSel;
    logic [63:0] pwMask;
    logic [15:0] mainWMask;
    logic bitVal;
    logic doBit;
    always_comb begin
        nxt_dir = dir_ff;
        nxt_outLat = outLat_ff;
        nxt_mainLat = mainLat_ff;
        nxt_ptSel = ptSel_ff;
        nxt_blkSel = blkSel_ff;
        nxt_nv = nv_ff;
        nxt_loaded = loaded_ff;
        pwArg = avsWriteData[15:0];
        pwSel = '0;
        pwMask = '0;
        mainWMask = bigVariant ? 16'hffff : 16'h00ff;
        bitVal = 1'b0;
        doBit = 1'b0;
        case (nv_ff)
            XIO_NV_IDLE: begin
                if (!loaded_ff) begin
                    if (nvHasData) begin
                        nxt_nv = XIO_NV_LOAD;
                    end else begin
                        nxt_loaded = 1'b1;
                    end
                end else if (avsWrite) begin
                    if (regIdx == XIO_REG_DIR) begin
                        nxt_dir = avsWriteData[7:0];
                    end else if (regIdx == XIO_REG_PTSEL) begin
                        nxt_ptSel = avsWriteData[6:0];
                        nxt_blkSel = avsWriteData[11:8];
                    end else if (regIdx == XIO_REG_BITCMD) begin
                        doBit = 1'b1;
                        if (avsWriteData[XIO_BITCMD_COND]) begin
                            bitVal = avsWriteData[XIO_BITCMD_CVAL];
                        end else begin
                            bitVal = avsWriteData[XIO_BITCMD_SET];
                        end
                        doBit = avsWriteData[XIO_BITCMD_COND] | avsWriteData[XIO_BITCMD_SET]
                            | avsWriteData[XIO_BITCMD_CLR];
                    end else if (regIdx == XIO_REG_MAIN) begin
                        nxt_mainLat = avsWriteData[15:0] & mainWMask;
                    end else if (regIdx >= XIO_REG_EXTA && regIdx <= XIO_REG_EXTD) begin
                        pwSel = 2'(regIdx - XIO_REG_EXTA);
                        pwMask[pwSel*16 +: 16] = 16'hffff;
                        pwMask = pwMask & outMask;
                        nxt_outLat = (outLat_ff & ~pwMask) | ({4{pwArg}} & pwMask);
                    end else if (regIdx == XIO_REG_SAVE) begin
                        nxt_nv = XIO_NV_SAVE;
                    end
                end
                if (doBit) begin
                    if (extValid(ptSel_ff)) begin
                        nxt_outLat[extIdx(ptSel_ff)] = bitVal;
                    end else if (ptSel_ff >= 7'h01 && ptSel_ff <= (bigVariant ? XIO_MAIN_LAST_BIG : XIO_MAIN_LAST)) begin
                        nxt_mainLat[4'(ptSel_ff - 7'h01)] = bitVal;
                    end
                end
            end
            XIO_NV_SAVE: begin
                if (nvDone) begin
                    nxt_nv = XIO_NV_IDLE;
                end
            end
            XIO_NV_LOAD: begin
                if (nvReadValid) begin
                    nxt_dir = nvReadData[87:80];
                    nxt_outLat = nvReadData[79:16];
                    nxt_mainLat = nvReadData[15:0];
                    nxt_loaded = 1'b1;
                    nxt_nv = XIO_NV_IDLE;
                end
            end
            default: nxt_nv = XIO_NV_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dir_ff <= XIO_DIR_RESET;
            outLat_ff <= '0;
            mainLat_ff <= '0;
            ptSel_ff <= '0;
            blkSel_ff <= '0;
            nv_ff <= XIO_NV_IDLE;
            loaded_ff <= 1'b0;
        end else if (clkEn) begin
            dir_ff <= nxt_dir;
            outLat_ff <= nxt_outLat;
            mainLat_ff <= nxt_mainLat;
            ptSel_ff <= nxt_ptSel;
            blkSel_ff <= nxt_blkSel;
            nv_ff <= nxt_nv;
            loaded_ff <= nxt_loaded;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; reads answer one cycle after they are presented
    logic [63:0] ptState;
    logic [15:0] mainState;
    always_comb begin
        ptState = (outLat_ff & outMask) | (pinStable_ff & ~outMask);
        if (bigVariant && !dir_ff[0]) begin
            ptState[7:0] = 8'h00;
        end
        mainState = mainStable_ff;
        nxt_rdDone = avsRead && !rdDone_ff;
        nxt_rdData = '0;
        if (regIdx == XIO_REG_DIR) begin
            nxt_rdData[7:0] = dir_ff;
        end else if (regIdx == XIO_REG_PTSEL) begin
            nxt_rdData = {20'h0, blkSel_ff, 1'b0, ptSel_ff};
        end else if (regIdx == XIO_REG_MAIN) begin
            nxt_rdData[15:0] = mainLat_ff;
        end else if (regIdx >= XIO_REG_EXTA && regIdx <= XIO_REG_EXTD) begin
            nxt_rdData[15:0] = outLat_ff[2'(regIdx - XIO_REG_EXTA)*16 +: 16];
        end else if (regIdx == XIO_REG_BLKRD) begin
            if (blkSel_ff == 4'h0) begin
                nxt_rdData[7:0] = mainState[7:0];
            end else if (blkSel_ff >= XIO_BLK_FIRST && blkSel_ff <= XIO_BLK_LAST) begin
                nxt_rdData[7:0] = ptState[3'(blkSel_ff - XIO_BLK_FIRST)*8 +: 8];
            end
        end else if (regIdx == XIO_REG_BITRD) begin
            if (extValid(ptSel_ff)) begin
                nxt_rdData[0] = ptState[extIdx(ptSel_ff)];
            end else if (ptSel_ff >= 7'h01 && ptSel_ff <= XIO_MAIN_LAST_BIG) begin
                nxt_rdData[0] = mainState[4'(ptSel_ff - 7'h01)];
            end
        end else if (regIdx == XIO_REG_STAT) begin
            nxt_rdData[XIO_STAT_BUSY] = (nv_ff != XIO_NV_IDLE) || !loaded_ff;
            nxt_rdData[XIO_STAT_VALID] = loaded_ff;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_ff <= '0;
            rdDone_ff <= 1'b0;
        end else if (clkEn) begin
            rdData_ff <= nxt_rdData;
            rdDone_ff <= nxt_rdDone;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writes complete only when the sequencer is idle and loaded
    assign avsWaitRequest = avsRead ? !rdDone_ff : (avsWrite && (nv_ff != XIO_NV_IDLE || !loaded_ff));
    assign avsReadData = rdData_ff;
    assign avsResponse = 2'b00;
    assign extPinOut = outLat_ff & outMask;
    assign extPinOe = outMask;
    assign mainOut = mainLat_ff;
    assign nvWrite = (nv_ff == XIO_NV_SAVE);
    assign nvWriteData = {dir_ff, outLat_ff, mainLat_ff};
    assign nvRead = (nv_ff == XIO_NV_LOAD);
endmodule : xio_ext_io
`default_nettype wire

/* File: sim/xio_ext_io_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module xio_ext_io_checker
    import xio_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic bigVariant,
    input wire logic [5:0] avsAddress,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic avsWaitRequest,
    input wire logic [63:0] extPinOut,
    input wire logic [63:0] extPinOe,
    input wire logic [15:0] mainOut,
    input wire logic nvWrite,
    input wire logic nvRead
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic wrOk, wrExt;
    logic [3:0] wIdx;
    logic [5:0] sh;
    logic [7:0] oe;
    assign wrOk = avsWrite && !avsWaitRequest;
    assign wIdx = avsAddress[5:2];
    assign wrExt = wrOk && wIdx inside {[XIO_REG_EXTA:XIO_REG_EXTD]};
    assign sh = {wIdx[1:0], 4'h0};
    assign oe = {extPinOe[56], extPinOe[48], extPinOe[40], extPinOe[32], extPinOe[24], extPinOe[16], extPinOe[8], extPinOe[0]};
    ////////////////////////////////////////////////////////////////////////////////
    property p_blk_group; extPinOe == {{8{oe[7]}}, {8{oe[6]}}, {8{oe[5]}}, {8{oe[4]}}, {8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}}; endproperty
    a_blk_group: assert property (p_blk_group) else $error("block enable split");
    property p_dir_map; wrOk && wIdx == XIO_REG_DIR |=> oe == $past(avsWriteData[7:0]); endproperty
    a_dir_map: assert property (p_dir_map) else $error("direction map wrong");
    property p_oe_cause; !$stable(extPinOe) |-> $past(wrOk && wIdx == XIO_REG_DIR) || $past(nvRead); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("direction changed unasked");
    property p_no_drive; (extPinOut & ~extPinOe) == 64'h0; endproperty
    a_no_drive: assert property (p_no_drive) else $error("input point driven");
    property p_ext_word; wrExt |=> 16'(extPinOut >> $past(sh)) == ($past(avsWriteData[15:0]) & 16'(extPinOe >> $past(sh))); endproperty
    a_ext_word: assert property (p_ext_word) else $error("word write wrong");
    property p_ext_keep; wrExt |=> ((extPinOut ^ $past(extPinOut)) & ~(64'hffff << $past(sh))) == 64'h0; endproperty
    a_ext_keep: assert property (p_ext_keep) else $error("other points changed");
    property p_main_byte; wrOk && wIdx == XIO_REG_MAIN && !bigVariant |=> mainOut[7:0] == $past(avsWriteData[7:0]); endproperty
    a_main_byte: assert property (p_main_byte) else $error("main byte wrong");
    property p_main_wide; wrOk && wIdx == XIO_REG_MAIN && bigVariant |=> mainOut == $past(avsWriteData[15:0]); endproperty
    a_main_wide: assert property (p_main_wide) else $error("main word wrong");
    property p_save_go; wrOk && wIdx == XIO_REG_SAVE |-> ##[0:4] nvWrite; endproperty
    a_save_go: assert property (p_save_go) else $error("save not started");
endmodule : xio_ext_io_checker
`default_nettype wire

/* File: sim/xio_rack_model.sv */
`timescale 1ns/10ps
`default_nettype none
module xio_rack_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] dly,
    input wire logic [63:0] rackIn,
    input wire logic [63:0] extPinOut,
    input wire logic [63:0] extPinOe,
    output logic [63:0] extPinIn,
    input wire logic nvWrite,
    input wire logic [87:0] nvWriteData,
    input wire logic nvRead,
    output logic nvReadValid,
    output logic [87:0] nvReadData,
    output logic nvHasData,
    output logic nvDone
);
    logic [87:0] img;
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // Driven points loop back, others show the rack
    assign extPinIn = (extPinOe & extPinOut) | (~extPinOe & rackIn);
    // Data lines carry garbage outside the valid pulse
    assign nvReadData = nvReadValid ? img : ~img;
    initial nvHasData = 1'b0;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            nvDone <= 1'b0;
            nvReadValid <= 1'b0;
        end else begin
            cnt <= (nvWrite || nvRead) && cnt != dly && !nvDone && !nvReadValid ? cnt + 4'h1 : 4'h0;
            nvDone <= nvWrite && cnt == dly;
            nvReadValid <= nvRead && cnt == dly;
            if (nvWrite && cnt == dly) img <= nvWriteData;
            if (nvWrite && cnt == dly) nvHasData <= 1'b1;
        end
    end
endmodule : xio_rack_model
`default_nettype wire

/* File: sim/tb_extended_io_block_config.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_extended_io_block_config
    import xio_pkg::*;
;
    localparam logic [63:0] RACK = 64'h8e3c_51a7_6b02_d9f5;
    logic clock, avsWaitRequest, nvWrite, nvRead, nvReadValid, nvHasData, nvDone;
    logic nrst = 1'b0, bigVariant = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
    logic [1:0] avsResponse;
    logic [3:0] dly = 4'h1;
    logic [3:0] cmdTab [4] = '{4'h1, 4'h4, 4'hc, 4'h2};
    logic [5:0] avsAddress = 6'h00;
    logic [15:0] mainOut, mainIn = 16'h5a3c;
    logic [31:0] avsReadData, rdv, avsWriteData = 32'h0;
    logic [63:0] extPinIn, extPinOut, extPinOe;
    logic [87:0] nvWriteData, nvReadData;
    int n_fail = 0, comparisons = 0, cyc = 0;
    xio_ext_io dut (.clkEn(1'b1), .avsByteEnable(4'hf), .*);
    xio_rack_model rack (.rackIn(RACK), .*);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    task stop_test;
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request holds until the rising edge that sees waitrequest low
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        avsAddress <= {a, 2'b00};
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        @(posedge clock);
        while (avsWaitRequest !== 1'b0) @(posedge clock);
        rdv = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clock);
    endtask : acc
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        chk(extPinOe, 64'h0, "oe");
        for (int k = 0; k < 8; k++) begin
            acc(1'b1, XIO_REG_DIR, 32'h1 << k);
            chk(extPinOe, 64'hff << 8 * k, "oe");
        end
        acc(1'b1, XIO_REG_DIR, 32'h0c);
        chk(extPinOe, 64'hffff_0000, "oe");
        acc(1'b1, XIO_REG_DIR, 32'h77);
        chk(extPinOe, 64'h00ff_ffff_00ff_ffff, "rack oe");
        acc(1'b0, 4'hf, 32'h0);
        chk(64'(rdv), 64'h0, "unmapped");
        acc(1'b1, XIO_REG_DIR, 32'hff);
        for (int k = 4; k < 8; k++) acc(1'b1, 4'(k), 32'hffff);
        acc(1'b1, XIO_REG_DIR, 32'h40);
        chk(extPinOut, 64'h00ff << 48, "masked");
        acc(1'b1, XIO_REG_MAIN, 32'h7);
        acc(1'b1, XIO_REG_EXTD, 32'h7);
        chk(64'(mainOut[7:0]), 64'h7, "main");
        chk(extPinOut, 64'h0007 << 48, "word");
        acc(1'b1, XIO_REG_DIR, 32'hff);
        chk(extPinOut, 64'hff07_ffff_ffff_ffff, "kept");
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, XIO_REG_PTSEL, i[0] ? 32'h50 : 32'h11);
            acc(1'b1, XIO_REG_BITCMD, 32'(cmdTab[i]));
            chk(64'(extPinOut[i[0] ? 63 : 0]), 64'(cmdTab[i][1] | cmdTab[i][3]), "bit");
        end
        acc(1'b1, XIO_REG_DIR, 32'h0);
        acc(1'b1, XIO_REG_PTSEL, 32'h14);
        acc(1'b1, XIO_REG_BITCMD, 32'h2);
        chk(extPinOe | extPinOut, 64'h0, "undriven");
        acc(1'b1, XIO_REG_PTSEL, 32'h11);
        acc(1'b0, XIO_REG_BITRD, 32'h0);
        chk(64'(rdv[0]), 64'(RACK[0]), "bit read");
        for (int b = 0; b < 10; b++) begin
            if (b == 1) continue;
            acc(1'b1, XIO_REG_PTSEL, 32'(b) << 8);
            acc(1'b0, XIO_REG_BLKRD, 32'h0);
            chk(64'(rdv), b == 0 ? 64'(mainIn[7:0]) : (RACK >> (8 * b - 16)) & 64'hff, "block");
        end
        bigVariant <= 1'b1;
        acc(1'b1, XIO_REG_PTSEL, 32'h200);
        acc(1'b0, XIO_REG_BLKRD, 32'h0);
        chk(64'(rdv), 64'h0, "big block");
        acc(1'b1, XIO_REG_MAIN, 32'habcd);
        chk(64'(mainOut), 64'habcd, "big main");
        acc(1'b1, XIO_REG_DIR, 32'h0c);
        acc(1'b1, XIO_REG_EXTB, 32'h1234);
        acc(1'b1, XIO_REG_SAVE, 32'h0);
        while (nvHasData !== 1'b1) @(posedge clock);
        chk(64'({rack.img[87:80], rack.img[47:32], rack.img[15:0]}), 64'h0c_1234_abcd, "image");
        nrst <= 1'b0;
        dly <= 4'h5;
        @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        rdv = 32'h0;
        while (rdv[XIO_STAT_VALID] !== 1'b1) acc(1'b0, XIO_REG_STAT, 32'h0);
        chk(extPinOe, 64'hffff_0000, "restored oe");
        chk({extPinOut[47:0], mainOut}, 64'h1234_0000_abcd, "restored");
        stop_test();
    end
endmodule : tb_extended_io_block_config

bind xio_ext_io xio_ext_io_checker u_chk (.*);
`default_nettype wire
